// ---- rtl/rtdi_i2c_slave.sv ----
`timescale 1ns/1ps
// How it works
// [R1] Idle bus: both lines released high
// [R2] SDA fall with SCL high starts transfer
// [R3] SDA rise with SCL high returns idle
// [R4] Eight bits per byte, then ack slot
// [R5] Bits shift most significant first
// [R6] No byte count limit per transfer
// [R7] SCL held low while data not ready
// [R8] Host clocks every ack slot
// [R9] Transmitter releases, receiver drives ack low
// [R10] Unmatched address leaves SDA high
// [R11] Refused data byte gets no ack
// [R12] First byte is address plus direction
// [R13] Matched address and written bytes acked low
// [R14] Other addresses ignored until next start
// [R15] Direction one makes device transmit
// [R16] Next read byte only after host ack
// [R17] Host nack ends read, SDA released
// [R18] Strap pin picks address 0x48 or 0x49
// [R19] Host checks ack and may resend
// [R20] Host waits for SCL actually high
// [R21] Six fixed address bits plus strap bit
// [R22] First write byte loads register pointer
// [R23] Temperature read gives six bytes, high first
// [R24] Pins synchronised and filtered before use; strap pin is synchronised only, not filtered
// [R25] Pointer kept across transfers
module rtdi_i2c_slave
  import rtdi_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       link_clk,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       address_strap_pin,
  input  rtdi_temp_t      temp_in,
  output logic            wr_stb,
  output rtdi_wr_t        wr_info
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic              scl_s1_q, scl_s2_q, sda_s1_q, sda_s2_q;
  logic              strap_s1_q, strap_s2_q, ack_s1_q, ack_s2_q;
  logic [1:0]        scl_h_q, sda_h_q;
  logic              scl_f_q, sda_f_q, scl_o_q, sda_o_q, scl_f_d, sda_f_d;
  logic              scl_rise, scl_fall, start_ev, stop_ev;
  rtdi_state_t       st_q, st_d;
  logic [3:0]        cnt_q, cnt_d;
  logic [7:0]        rx_q, rx_d, tx_q, tx_d;
  logic              rw_q, rw_d, first_q, first_d;
  logic [1:0]        ptr_q, ptr_d;
  logic [2:0]        idx_q, idx_d;
  logic              sda_oe_q, sda_oe_d, scl_oe_q, scl_oe_d;
  logic              req_tgl_q, req_tgl_d, ack_seen_q, ack_seen_d;
  logic              wr_tgl_q, wr_tgl_d;
  rtdi_wr_t          wr_q, wr_d;
  logic [3:1][15:0]  regs_q, regs_d;
  rtdi_temp_t        buf_q, buf_d;
  logic              req_s1_q, req_s2_q, wr_s1_q, wr_s2_q;
  logic              req_seen_q, req_seen_d, ack_tgl_q, ack_tgl_d;
  logic              wr_seen_q, wr_seen_d, wr_stb_q, wr_stb_d;
  rtdi_wr_t          wr_info_q, wr_info_d;
  rtdi_temp_t        snap_q, snap_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] pick(input logic [1:0] p, input logic [2:0] i,
                                      input rtdi_temp_t t, input logic [3:1][15:0] r);
    logic [47:0] sh;
    sh = 48'(t) >> (6'd40 - {i, 3'b000});
    pick = (p == PTR_TEMP) ? sh[7:0] : (i[0] ? r[p][7:0] : r[p][15:8]);  // see [R23]
  endfunction
  function automatic logic [2:0] next_idx(input logic [1:0] p, input logic [2:0] i);
    logic [2:0] lim;
    lim = (p == PTR_TEMP) ? TEMP_BYTES : REG_BYTES;
    next_idx = (i + 3'h1 == lim) ? 3'h0 : i + 3'h1;          // see [R6]
  endfunction

  // ----------------------------------------------------------------
  // Pin sampling on the link clock
  // ----------------------------------------------------------------
  // Short filter: a line only changes after three equal samples
  always_comb begin
    scl_f_d = (scl_h_q == {2{scl_s2_q}}) ? scl_s2_q : scl_f_q;  // see [R24]
    sda_f_d = (sda_h_q == {2{sda_s2_q}}) ? sda_s2_q : sda_f_q;  // see [R24]
  end
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      {scl_s1_q, scl_s2_q, sda_s1_q, sda_s2_q, scl_h_q, sda_h_q} <= 8'hff;
      {strap_s1_q, strap_s2_q, ack_s1_q, ack_s2_q} <= 4'h0;
      {scl_f_q, sda_f_q, scl_o_q, sda_o_q} <= 4'hf;
    end else begin
      scl_s1_q   <= scl_in;
      scl_s2_q   <= scl_s1_q;
      sda_s1_q   <= sda_in;
      sda_s2_q   <= sda_s1_q;
      strap_s1_q <= address_strap_pin;
      strap_s2_q <= strap_s1_q;
      ack_s1_q   <= ack_tgl_q;
      ack_s2_q   <= ack_s1_q;
      scl_h_q    <= {scl_h_q[0], scl_s2_q};
      sda_h_q    <= {sda_h_q[0], sda_s2_q};
      scl_f_q    <= scl_f_d;
      sda_f_q    <= sda_f_d;
      scl_o_q    <= scl_f_q;
      sda_o_q    <= sda_f_q;
    end
  end

  assign scl_rise = scl_f_q & ~scl_o_q;
  assign scl_fall = ~scl_f_q & scl_o_q;
  assign start_ev = scl_f_q & scl_o_q & ~sda_f_q & sda_o_q;  // see [R2]
  assign stop_ev  = scl_f_q & scl_o_q & sda_f_q & ~sda_o_q;  // see [R3]

  // ----------------------------------------------------------------
  // Bus engine
  // ----------------------------------------------------------------
  always_comb begin
    st_d       = st_q;
    cnt_d      = cnt_q;
    rx_d       = rx_q;
    tx_d       = tx_q;
    rw_d       = rw_q;
    first_d    = first_q;
    ptr_d      = ptr_q;
    idx_d      = idx_q;
    sda_oe_d   = sda_oe_q;
    scl_oe_d   = scl_oe_q;
    req_tgl_d  = req_tgl_q;
    ack_seen_d = (st_q == ST_SNAP) ? ack_seen_q : ack_s2_q;
    wr_tgl_d   = wr_tgl_q;
    wr_d       = wr_q;
    regs_d     = regs_q;
    buf_d      = buf_q;
    if (start_ev) begin
      st_d     = ST_ADDR;                                      // see [R2]
      cnt_d    = 4'h0;
      sda_oe_d = 1'b0;
      scl_oe_d = 1'b0;
    end else if (stop_ev) begin
      st_d     = ST_IDLE;                                      // see [R3]
      sda_oe_d = 1'b0;                                         // see [R1]
      scl_oe_d = 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          sda_oe_d = 1'b0;                                     // see [R14]
        end
        ST_ADDR: begin
          if (scl_rise) begin
            rx_d  = {rx_q[6:0], sda_f_q};                      // see [R5]
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == BYTE_BITS) begin   // see [R12]
            if (rx_q[7:1] == {DEV_ADDR_HI, strap_s2_q}) begin  // see [R18] [R21]
              rw_d     = rx_q[0];
              first_d  = 1'b1;
              sda_oe_d = 1'b1;                                 // see [R13]
              st_d     = ST_ADDR_ACK;
            end else begin
              st_d = ST_IDLE;                                  // see [R10] [R14]
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            cnt_d = 4'h0;
            idx_d = 3'h0;
            if (!rw_q) begin
              sda_oe_d = 1'b0;
              st_d     = ST_WR;
            end else if (ptr_q == PTR_TEMP) begin
              // Fresh pair fetched from the core side; hold SCL low meanwhile
              sda_oe_d  = 1'b0;
              scl_oe_d  = 1'b1;                                // see [R7]
              req_tgl_d = ~req_tgl_q;
              st_d      = ST_SNAP;
            end else begin
              tx_d     = pick(ptr_q, 3'h0, buf_q, regs_q);     // see [R15] [R25]
              sda_oe_d = ~tx_d[7];
              st_d     = ST_RD;
            end
          end
        end
        ST_SNAP: begin
          if (ack_s2_q != ack_seen_q) begin
            ack_seen_d = ack_s2_q;
            buf_d      = snap_q;
            tx_d       = pick(PTR_TEMP, 3'h0, snap_q, regs_q); // see [R15]
            sda_oe_d   = ~tx_d[7];
            scl_oe_d   = 1'b0;                                 // see [R7]
            st_d       = ST_RD;
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (cnt_q == LAST_BIT) begin
              sda_oe_d = 1'b0;                                 // see [R9] [R4]
              st_d     = ST_RD_ACK;
            end else begin
              tx_d     = {tx_q[6:0], 1'b0};                    // see [R5]
              sda_oe_d = ~tx_q[6];
              cnt_d    = cnt_q + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise && sda_f_q) begin
            st_d = ST_IDLE;                                    // see [R17]
          end else if (scl_fall) begin
            idx_d    = next_idx(ptr_q, idx_q);                 // see [R16]
            tx_d     = pick(ptr_q, idx_d, buf_q, regs_q);
            sda_oe_d = ~tx_d[7];
            cnt_d    = 4'h0;
            st_d     = ST_RD;
          end
        end
        ST_WR: begin
          if (scl_rise) begin
            rx_d  = {rx_q[6:0], sda_f_q};                      // see [R5]
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == BYTE_BITS) begin   // see [R4]
            sda_oe_d = 1'b1;                                   // see [R13]
            st_d     = ST_WR_ACK;
            if (first_q) begin
              ptr_d   = rx_q[1:0];                             // see [R22]
              idx_d   = 3'h0;
              first_d = 1'b0;
            end else if (ptr_q == PTR_TEMP) begin
              // Measurement pair is read only: refuse the byte
              sda_oe_d = 1'b0;                                 // see [R11]
              st_d     = ST_IDLE;
            end else begin
              if (!idx_q[0]) begin
                regs_d[ptr_q][15:8] = rx_q;                    // see [R22]
              end else begin
                regs_d[ptr_q][7:0] = rx_q;
              end
              wr_d     = '{ptr: ptr_q, idx: idx_q, data: rx_q};
              wr_tgl_d = ~wr_tgl_q;
              idx_d    = next_idx(ptr_q, idx_q);               // see [R6]
            end
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            sda_oe_d = 1'b0;                                   // see [R9]
            cnt_d    = 4'h0;
            st_d     = ST_WR;
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q       <= ST_IDLE;
      ptr_q      <= PTR_RESET;
      regs_q     <= {3{REG_RESET}};
      {cnt_q, rx_q, tx_q, rw_q, first_q, idx_q, sda_oe_q, scl_oe_q} <= 27'h0;
      {req_tgl_q, ack_seen_q, wr_tgl_q, wr_q, buf_q}                 <= 64'h0;
    end else begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      rx_q       <= rx_d;
      tx_q       <= tx_d;
      rw_q       <= rw_d;
      first_q    <= first_d;
      ptr_q      <= ptr_d;
      idx_q      <= idx_d;
      sda_oe_q   <= sda_oe_d;
      scl_oe_q   <= scl_oe_d;
      req_tgl_q  <= req_tgl_d;
      ack_seen_q <= ack_seen_d;
      wr_tgl_q   <= wr_tgl_d;
      wr_q       <= wr_d;
      regs_q     <= regs_d;
      buf_q      <= buf_d;
    end
  end

  // Open drain: only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = scl_oe_q;
  assign sda_oe  = sda_oe_q;

  // ----------------------------------------------------------------
  // Core side
  // ----------------------------------------------------------------
  // Toggles cross; the data they announce stays still until the next one
  always_comb begin
    req_seen_d = req_seen_q;
    ack_tgl_d  = ack_tgl_q;
    snap_d     = snap_q;
    wr_seen_d  = wr_seen_q;
    wr_stb_d   = 1'b0;
    wr_info_d  = wr_info_q;
    if (req_s2_q != req_seen_q) begin
      req_seen_d = req_s2_q;
      snap_d     = temp_in;                                    // see [R23]
      ack_tgl_d  = ~ack_tgl_q;
    end
    if (wr_s2_q != wr_seen_q) begin
      wr_seen_d = wr_s2_q;
      wr_stb_d  = 1'b1;
      wr_info_d = wr_q;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      {req_s1_q, req_s2_q, wr_s1_q, wr_s2_q} <= 4'h0;
      {req_seen_q, ack_tgl_q, snap_q, wr_seen_q, wr_stb_q, wr_info_q} <= 65'h0;
    end else begin
      req_s1_q   <= req_tgl_q;
      req_s2_q   <= req_s1_q;
      wr_s1_q    <= wr_tgl_q;
      wr_s2_q    <= wr_s1_q;
      req_seen_q <= req_seen_d;
      ack_tgl_q  <= ack_tgl_d;
      snap_q     <= snap_d;
      wr_seen_q  <= wr_seen_d;
      wr_stb_q   <= wr_stb_d;
      wr_info_q  <= wr_info_d;
    end
  end

  assign wr_stb  = wr_stb_q;
  assign wr_info = wr_info_q;
endmodule

// ---- pkg/rtdi_pkg.sv ----
package rtdi_pkg;

  // ----------------------------------------------------------------
  // Address, pointer and sizes
  // ----------------------------------------------------------------
  localparam logic [5:0] DEV_ADDR_HI  = 6'h24;
  localparam logic [1:0] PTR_TEMP     = 2'h0;
  localparam logic [1:0] PTR_RESET    = 2'h0;
  localparam logic [2:0] TEMP_BYTES   = 3'h6;
  localparam logic [2:0] REG_BYTES    = 3'h2;
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam logic [3:0] LAST_BIT     = 4'h7;
  localparam logic [15:0] REG_RESET   = 16'h0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [23:0] ch1;
    logic [23:0] ch2;
  } rtdi_temp_t;

  typedef struct packed {
    logic [1:0] ptr;
    logic [2:0] idx;
    logic [7:0] data;
  } rtdi_wr_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_ADDR     = 3'h1,
    ST_ADDR_ACK = 3'h2,
    ST_WR       = 3'h3,
    ST_WR_ACK   = 3'h4,
    ST_SNAP     = 3'h5,
    ST_RD       = 3'h6,
    ST_RD_ACK   = 3'h7
  } rtdi_state_t;

endpackage

// ---- verif/rtdi_i2c_slave_asserts.sv ----
`timescale 1ns/1ps
module rtdi_i2c_slave_asserts
  import rtdi_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       link_clk,
  input wire logic       scl_in,
  input wire logic       scl_out,
  input wire logic       scl_oe,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       address_strap_pin,
  input wire rtdi_temp_t temp_in,
  input wire logic       wr_stb,
  input wire rtdi_wr_t   wr_info
);
  // ----------------------------------------------------------------
  // Bus side
  // ----------------------------------------------------------------
  sequence s_stop;
    scl_in && $rose(sda_in);
  endsequence

  sequence s_freed;
    (!sda_oe && !scl_oe) [*8];
  endsequence

  open_drain_a: assert property (@(posedge clock) disable iff (!rst_b) !scl_out && !sda_out)
    else $error("pin driven high");
  ack_change_a: assert property (@(posedge link_clk) disable iff (!rst_b) $changed(sda_oe) |-> !scl_in)
    else $error("sda changed while scl high");
  stretch_low_a: assert property (@(posedge link_clk) disable iff (!rst_b) $rose(scl_oe) |-> !scl_in)
    else $error("stretch began with scl high");
  stretch_end_a: assert property (@(posedge link_clk) disable iff (!rst_b) $rose(scl_oe) |-> ##[1:100] !scl_oe)
    else $error("scl held too long");
  stop_idle_a: assert property (@(posedge link_clk) disable iff (!rst_b) s_stop |-> ##1 s_freed)
    else $error("lines not released after stop");
  // ----------------------------------------------------------------
  // Core side
  // ----------------------------------------------------------------
  wr_pulse_a: assert property (@(posedge clock) disable iff (!rst_b) wr_stb |=> !wr_stb)
    else $error("write strobe longer than one cycle");
  wr_ptr_a: assert property (@(posedge clock) disable iff (!rst_b) wr_stb |-> wr_info.ptr != PTR_TEMP)
    else $error("write to read-only pointer");
  info_hold_a: assert property (@(posedge clock) disable iff (!rst_b) !wr_stb |-> $stable(wr_info))
    else $error("write info changed without strobe");
endmodule

bind rtdi_i2c_slave rtdi_i2c_slave_asserts chk_u (.clock, .rst_b, .link_clk, .scl_in, .scl_out, .scl_oe,
  .sda_in, .sda_out, .sda_oe, .address_strap_pin, .temp_in, .wr_stb, .wr_info);

// ---- verif/rtdi_host_model.sv ----
`timescale 1ns/1ps
module rtdi_host_model
  import rtdi_pkg::*;
#(
  parameter int QTR = 50
)
(
  input  wire logic clock,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_pull,
  output logic      sda_pull
);
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end

  task automatic gap();
    repeat (QTR) @(posedge clock);
  endtask

  // Released clock may be held low by the device
  task automatic scl_up();
    int k;
    k = 0;
    scl_pull <= 1'b0;
    @(posedge clock);
    while (!scl && k < 2000) begin
      @(posedge clock);
      k++;
    end
    gap();
  endtask

  task automatic start_cond();
    sda_pull <= 1'b0;
    gap();
    scl_up();
    sda_pull <= 1'b1;
    gap();
    scl_pull <= 1'b1;
    gap();
  endtask

  task automatic stop_cond();
    sda_pull <= 1'b1;
    gap();
    scl_up();
    sda_pull <= 1'b0;
    gap();
  endtask

  task automatic one_bit(input logic b, output logic r);
    sda_pull <= !b;
    gap();
    scl_up();
    r = sda;
    scl_pull <= 1'b1;
    gap();
  endtask

  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      one_bit(tx[i], rx[i]);
    end
    one_bit(ack_in, ack);
  endtask
endmodule

// ---- verif/test_rtdi_i2c_slave.sv ----
`timescale 1ns/1ps
module test_rtdi_i2c_slave
  import rtdi_pkg::*;
;
  logic       clock;
  logic       link_clk;
  logic       rst_b;
  logic       strap;
  rtdi_temp_t temp;
  logic       scl_oe;
  logic       sda_oe;
  logic       wr_stb;
  rtdi_wr_t   wr_info;
  logic       h_scl;
  logic       h_sda;
  logic       scl_w;
  logic       sda_w;
  logic       stretch_seen;
  logic [7:0] rx;
  logic       ack;
  int         n_fail;
  int         samples_checked;
  rtdi_wr_t   wr_q[$];

  // Wired lines with pull-up
  assign scl_w = !(scl_oe | h_scl);
  assign sda_w = !(sda_oe | h_sda);

  rtdi_i2c_slave dut_u (.clock(clock), .rst_b(rst_b), .link_clk(link_clk), .scl_in(scl_w), .scl_out(),
    .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe), .address_strap_pin(strap),
    .temp_in(temp), .wr_stb(wr_stb), .wr_info(wr_info));
  rtdi_host_model host_u (.clock(clock), .scl(scl_w), .sda(sda_w), .scl_pull(h_scl), .sda_pull(h_sda));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end

  always @(posedge clock) if (wr_stb === 1'b1) wr_q.push_back(wr_info);
  always @(posedge link_clk) if (scl_oe === 1'b1) stretch_seen <= 1'b1;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic send(input logic [7:0] tx, input logic exp_ack);
    host_u.xfer(tx, 1'b1, rx, ack);
    check({15'h0, ack}, {15'h0, exp_ack}, "ack");
  endtask

  task automatic fetch(input logic last, input logic [7:0] exp);
    host_u.xfer(8'hff, last, rx, ack);
    check({8'h0, rx}, {8'h0, exp}, "read byte");
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_write();
    host_u.start_cond();
    send(8'h90, 1'b0);
    send(8'h01, 1'b0);
    send(8'hab, 1'b0);
    send(8'hcd, 1'b0);
    host_u.stop_cond();
    check(16'(wr_q.size()), 16'h2, "strobes");
    check({3'h0, wr_q[0]}, {3'h0, 2'h1, 3'h0, 8'hab}, "first write");
    check({3'h0, wr_q[1]}, {3'h0, 2'h1, 3'h1, 8'hcd}, "second write");
    $display("test_write done");
  endtask

  // Pointer left from the write, no pointer byte here
  task automatic test_read_kept();
    host_u.start_cond();
    send(8'h91, 1'b0);
    fetch(1'b0, 8'hab);
    fetch(1'b0, 8'hcd);
    fetch(1'b1, 8'hab);
    host_u.stop_cond();
    check({15'h0, sda_oe}, 16'h0, "sda released");
    $display("test_read_kept done");
  endtask

  task automatic test_address();
    strap <= 1'b1;
    host_u.start_cond();
    send(8'h90, 1'b1);
    send(8'h02, 1'b1);
    host_u.stop_cond();
    host_u.start_cond();
    send(8'h92, 1'b0);
    host_u.stop_cond();
    strap <= 1'b0;
    $display("test_address done");
  endtask

  task automatic test_temp();
    logic [7:0] tbl[7] = '{8'h80, 8'h00, 8'h01, 8'h7f, 8'hff, 8'hfe, 8'h80};
    host_u.start_cond();
    send(8'h90, 1'b0);
    send(8'h00, 1'b0);
    send(8'h55, 1'b1);
    host_u.start_cond();
    send(8'h91, 1'b0);
    for (int i = 0; i < 7; i++) begin
      fetch(i == 6, tbl[i]);
    end
    host_u.stop_cond();
    check({15'h0, stretch_seen}, 16'h1, "clock held");
    check(16'(wr_q.size()), 16'h2, "stray strobes");
    $display("test_temp done");
  endtask

  // Upper register written, then read back after a repeated start
  task automatic test_regs();
    host_u.start_cond();
    send(8'h90, 1'b0);
    send(8'h03, 1'b0);
    send(8'h12, 1'b0);
    send(8'h34, 1'b0);
    host_u.start_cond();
    send(8'h91, 1'b0);
    fetch(1'b0, 8'h12);
    fetch(1'b1, 8'h34);
    host_u.stop_cond();
    check(16'(wr_q.size()), 16'h4, "upper strobes");
    check({3'h0, wr_q[3]}, {3'h0, 2'h3, 3'h1, 8'h34}, "upper write");
    $display("test_regs done");
  endtask

  initial begin
    rst_b = 1'b0;
    strap = 1'b0;
    temp = {24'h800001, 24'h7ffffe};
    stretch_seen = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    repeat (30) @(posedge clock);
    test_write();
    test_read_kept();
    test_address();
    test_temp();
    test_regs();
    finish_test();
  end

  // Run needs about 42000 cycles
  initial begin
    repeat (90000) @(posedge clock);
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule
